// [rtl/iev_pkg.sv]
/*
  Package of the interrupt enable and vector logic: register offsets,
  bit layout of the enable register, vector addresses and machine-cycle
  timing points. Assumes a single system clock and one 8-bit enable byte.
*/
package iev_pkg;

  // ----------------------------------------------------------------
  // Source indices (also the enable bit positions and poll order)
  // ----------------------------------------------------------------
  localparam int unsigned NUM_SRC  = 6;            // Vectored sources
  localparam int unsigned SRC_EXT0 = 0;            // External 0
  localparam int unsigned SRC_T0   = 1;            // Timer 0
  localparam int unsigned SRC_EXT1 = 2;            // External 1
  localparam int unsigned SRC_T1   = 3;            // Timer 1
  localparam int unsigned SRC_SER  = 4;            // UART and SPI
  localparam int unsigned SRC_T2   = 5;            // Timer 2
  localparam int unsigned BIT_RSVD = 6;            // Unimplemented bit
  localparam int unsigned BIT_GEN  = 7;            // Global enable

  // ----------------------------------------------------------------
  // Register map, byte addresses on the bus
  // ----------------------------------------------------------------
  localparam logic [7:0] ADR_FLAGS = 8'h00;        // Raw flag view, read only
  localparam logic [7:0] ADR_EVT   = 8'h04;        // Event status, write one to clear
  localparam logic [7:0] ADR_MASK  = 8'h08;        // Event mask
  localparam logic [7:0] ADR_VEC   = 8'h0C;        // Current vector and request
  localparam logic [7:0] ADR_IE    = 8'hA8;        // Interrupt enable register
  localparam logic [7:0] IE_RESET  = 8'h00;        // Enable reset value
  localparam logic [7:0] IE_WMASK  = 8'hBF;        // Reserved bit never stored

  // ----------------------------------------------------------------
  // Vector addresses
  // ----------------------------------------------------------------
  localparam logic [15:0] VEC_RESET = 16'h0000;    // System reset
  localparam logic [15:0] VEC_BASE  = 16'h0003;    // External 0
  localparam logic [15:0] VEC_STEP  = 16'h0008;    // Spacing of vectors

  // ----------------------------------------------------------------
  // Machine cycle: six states of two phases each
  // ----------------------------------------------------------------
  localparam logic [3:0] MC_LAST = 4'hB;           // Last phase slot
  localparam logic [3:0] MC_STATE2_PHASE2 = 4'h3;           // State 2 phase 2
  localparam logic [3:0] MC_STATE5_PHASE2 = 4'h9;           // State 5 phase 2

endpackage : iev_pkg

// [rtl/iev_src_if.sv]
/*
  Interface between the core of the interrupt logic and its poll encoder.
  Assumes both ends run on the same clock; it carries only wires.
*/
`timescale 1ns/1ps
interface iev_src_if;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic [5:0]  pending;                            // Enabled requests at poll
  logic [5:0]  grant;                              // One-hot winner
  logic        any;                                // Some request pending
  logic [15:0] vector;                             // Winner's vector address

  modport core (output pending, input grant, input any, input vector);
  modport enc  (input pending, output grant, output any, output vector);
endinterface : iev_src_if

// [rtl/iev_mcycle.sv]
/*
  Machine-cycle sequencer: counts the twelve phase slots of a machine
  cycle and marks state 2 phase 2 and state 5 phase 2.
  Assumes a synchronous active-low reset.
*/
`timescale 1ns/1ps
module iev_mcycle
  import iev_pkg::*;
(
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst_n,
  // Timing marks
  output logic      state2_phase2,
  output logic      state5_phase2
);
  logic [3:0] slot_q;                              // Phase slot counter

  // ----------------------------------------------------------------
  // Slot counter, wraps after the last slot
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      slot_q <= 4'h0;
    end else if (slot_q == MC_LAST) begin
      slot_q <= 4'h0;
    end else begin
      slot_q <= slot_q + 4'h1;
    end
  end

  assign state2_phase2 = (slot_q == MC_STATE2_PHASE2);
  assign state5_phase2 = (slot_q == MC_STATE5_PHASE2);
endmodule : iev_mcycle

// [rtl/iev_poll_enc.sv]
/*
  Poll encoder: fixed order, lowest source index wins, and the winner's
  vector address. Purely combinational; the core registers the result.
*/
`timescale 1ns/1ps
module iev_poll_enc
  import iev_pkg::*;
(
  // Request carrier
  iev_src_if.enc src
);
  // ----------------------------------------------------------------
  // One-hot grant, one generate entry per source
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NUM_SRC; gi++) begin : g_grant
      localparam logic [5:0] LOWER = 6'((7'h01 << gi) - 7'h01);
      assign src.grant[gi] = src.pending[gi] & ~|(src.pending & LOWER);
    end
  endgenerate

  assign src.any = |src.pending;

  // ----------------------------------------------------------------
  // Vector address: base plus index times step
  // ----------------------------------------------------------------
  always_comb begin
    src.vector = VEC_RESET;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (src.grant[i]) begin
        src.vector = VEC_BASE + 16'(VEC_STEP * 16'(i));
      end
    end
  end
endmodule : iev_poll_enc

// [rtl/iev_core.sv]
/*
  Interrupt enable and vector logic of an 8-bit controller core.
  Holds the enable register, latches the timer flags at their
  machine-cycle points, polls them with the serial and external flags, and offers one
  vectored request to the CPU core. Registers sit on a classic
  Wishbone slave. Assumes peripheral flags are levels on mclk and the
  external pins are asynchronous, active low, falling-edge triggered.
*/
// The implementer's own choice: the Wishbone register port.
// Behaviour
// - Six vectors: two external, three timers, serial
// - Per-source enable bit permits or blocks source
// - Global enable low blocks every interrupt; irq_o still follows stored masked events
// - Timer 2 request is overflow OR external
// - Timer 2 flags stay set; software clears
// - Serial request: receive, transmit, gated SPI done
// - Serial flags stay set; software finds source
// - Timer 0/1 latched state5_phase2, polled next cycle
// - Timer 2 latched state2_phase2, polled same cycle
// - Fixed vectors 0003, 000B, 0013, 001B, 0023, 002B
// - Enable bits: T2,serial,T1,ext1,T0,ext0 from 5
`timescale 1ns/1ps
module iev_core
  import iev_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // Wishbone slave
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_we_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // External interrupt pins, active low
  input  wire logic        ext_irq_pin_0_n,
  input  wire logic        ext_irq_pin_1_n,
  // Peripheral flags
  input  wire logic        timer0_overflow_flag,
  input  wire logic        timer1_overflow_flag,
  input  wire logic        timer2_overflow_flag,
  input  wire logic        timer2_external_flag,
  input  wire logic        uart_receive_flag,
  input  wire logic        uart_transmit_flag,
  input  wire logic        spi_done_flag,
  input  wire logic        spi_irq_enable,
  // CPU core request
  input  wire logic        irq_ack,
  output logic             irq_req,
  output logic [15:0]      irq_vector,
  output logic [5:0]       irq_source,
  // Event interrupt
  output logic             irq_o
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [7:0]  interrupt_enable_reg_q;            // Enable register
  logic [5:0]  evt_q;                             // Sticky event bits
  logic [5:0]  mask_q;                            // Event mask
  logic        irq_o_q;                           // Registered event irq
  logic        ack_q;                             // Bus acknowledge
  logic [31:0] dat_q;                             // Bus read data
  logic [1:0]  ext0_sync_q;                       // Pin 0 synchroniser
  logic [1:0]  ext1_sync_q;                       // Pin 1 synchroniser
  logic        ext0_prev_q;                       // Pin 0 last level
  logic        ext1_prev_q;                       // Pin 1 last level
  logic        ext0_request_flag_q;               // Edge seen on pin 0
  logic        ext1_request_flag_q;               // Edge seen on pin 1
  logic [1:0]  t01_latch_q;                       // Timer 0/1 latched flags
  logic        t2_latch_q;                        // Timer 2 latched request
  logic        irq_req_q;                         // Request to CPU
  logic [15:0] irq_vector_q;                      // Offered vector
  logic [5:0]  irq_src_q;                         // Offered source
  logic        state2_phase2;                     // Timer 2 latch point
  logic        state5_phase2;                     // Timer 0/1 latch and poll
  logic        bus_req;                           // New bus access
  logic        bus_wr;                            // Write with low byte lane
  logic        global_irq_enable;                 // Enable bit 7
  logic        serial_raw;                        // Combined serial request
  logic        ext0_fall;                         // Falling edge, pin 0
  logic        ext1_fall;                         // Falling edge, pin 1
  logic [5:0]  raw_req;                           // Source requests at poll
  logic [5:0]  evt_set;                           // Events this cycle
  logic [5:0]  evt_clr;                           // Write-one clears

  iev_src_if src ();

  // ----------------------------------------------------------------
  // Sub-blocks
  // ----------------------------------------------------------------
  iev_mcycle u_mcycle (
    .mclk          (mclk),
    .rst_n         (rst_n),
    .state2_phase2 (state2_phase2),
    .state5_phase2 (state5_phase2)
  );

  iev_poll_enc u_enc (
    .src (src.enc)
  );

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // One access per request; a write lands at the edge the master sees ack
  assign bus_req           = wb_cyc_i & wb_stb_i & ~ack_q;
  assign bus_wr            = wb_cyc_i & wb_stb_i & ack_q & wb_we_i & wb_sel_i[0];
  assign global_irq_enable = interrupt_enable_reg_q[BIT_GEN];

  // Acknowledge one cycle after the strobe, every address answers
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= bus_req;
    end
  end

  // Read mux, unmapped addresses read as zero
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      dat_q <= 32'h0000_0000;
    end else if (bus_req && !wb_we_i) begin
      unique case (wb_adr_i)
        ADR_IE:    dat_q <= {24'h00_0000, interrupt_enable_reg_q};
        ADR_EVT:   dat_q <= {26'h000_0000, evt_q};
        ADR_MASK:  dat_q <= {26'h000_0000, mask_q};
        ADR_VEC:   dat_q <= {8'h00, 1'b0, irq_req_q, irq_src_q, irq_vector_q};
        ADR_FLAGS: dat_q <= {24'h00_0000, spi_irq_enable, spi_done_flag,
                             uart_transmit_flag, uart_receive_flag,
                             timer2_external_flag, timer2_overflow_flag,
                             ext1_request_flag_q, ext0_request_flag_q};
        default:   dat_q <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Enable register
  // ----------------------------------------------------------------
  // The reserved bit is not stored, so a stray one reads back zero
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      interrupt_enable_reg_q <= IE_RESET;
    end else if (bus_wr && wb_adr_i == ADR_IE) begin
      interrupt_enable_reg_q <= wb_dat_i[7:0] & IE_WMASK;
    end
  end

  // ----------------------------------------------------------------
  // External pins: two-stage synchronisers, then edge flags
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ext0_sync_q <= 2'b11;
      ext1_sync_q <= 2'b11;
      ext0_prev_q <= 1'b1;
      ext1_prev_q <= 1'b1;
    end else begin
      ext0_sync_q <= {ext0_sync_q[0], ext_irq_pin_0_n};
      ext1_sync_q <= {ext1_sync_q[0], ext_irq_pin_1_n};
      ext0_prev_q <= ext0_sync_q[1];
      ext1_prev_q <= ext1_sync_q[1];
    end
  end

  assign ext0_fall = ext0_prev_q & ~ext0_sync_q[1];
  assign ext1_fall = ext1_prev_q & ~ext1_sync_q[1];

  // Edge flags clear when the CPU takes that vector; a new edge wins
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ext0_request_flag_q <= 1'b0;
      ext1_request_flag_q <= 1'b0;
    end else begin
      ext0_request_flag_q <= ext0_fall |
        (ext0_request_flag_q & ~(irq_ack & irq_req_q & irq_src_q[SRC_EXT0]));
      ext1_request_flag_q <= ext1_fall |
        (ext1_request_flag_q & ~(irq_ack & irq_req_q & irq_src_q[SRC_EXT1]));
    end
  end

  // ----------------------------------------------------------------
  // Flag latching at the machine-cycle points
  // ----------------------------------------------------------------
  // Timer 0/1 flags caught at state5_phase2; the poll at that same
  // edge still sees last cycle's latch, so they are polled next cycle
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      t01_latch_q <= 2'b00;
    end else if (state5_phase2) begin
      t01_latch_q <= {timer1_overflow_flag, timer0_overflow_flag};
    end
  end

  // Timer 2 caught at state2_phase2, before this cycle's poll
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      t2_latch_q <= 1'b0;
    end else if (state2_phase2) begin
      t2_latch_q <= timer2_overflow_flag | timer2_external_flag;
    end
  end

  // ----------------------------------------------------------------
  // Poll: gate each source by its enable and the global enable
  // ----------------------------------------------------------------
  assign serial_raw = uart_receive_flag | uart_transmit_flag |
                      (spi_done_flag & spi_irq_enable);

  assign raw_req[SRC_EXT0] = ext0_request_flag_q;
  assign raw_req[SRC_T0]   = t01_latch_q[0];
  assign raw_req[SRC_EXT1] = ext1_request_flag_q;
  assign raw_req[SRC_T1]   = t01_latch_q[1];
  assign raw_req[SRC_SER]  = serial_raw;
  assign raw_req[SRC_T2]   = t2_latch_q;

  // Six sources, one enable each, all blocked without the global bit
  assign src.pending = raw_req & interrupt_enable_reg_q[5:0] &
                       {NUM_SRC{global_irq_enable}};

  // ----------------------------------------------------------------
  // Request to the CPU core
  // ----------------------------------------------------------------
  // The ack or a low global enable drops the request; timer 2 and serial flags are left
  // untouched, the service routine clears them itself
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      irq_req_q <= 1'b0;
    end else if (!global_irq_enable) begin
      irq_req_q <= 1'b0;
    end else if (irq_req_q && irq_ack) begin
      irq_req_q <= 1'b0;
    end else if (!irq_req_q && state5_phase2) begin
      irq_req_q <= src.any;
    end
  end

  // Vector and source held steady while the request stands
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      irq_vector_q <= VEC_RESET;
      irq_src_q    <= 6'h00;
    end else if (!irq_req_q && state5_phase2) begin
      irq_vector_q <= src.vector;
      irq_src_q    <= src.grant;
    end
  end

  // ----------------------------------------------------------------
  // Event status, mask and interrupt output
  // ----------------------------------------------------------------
  assign evt_set = (!irq_req_q && state5_phase2) ? src.grant : 6'h00;
  assign evt_clr = (bus_wr && wb_adr_i == ADR_EVT) ? wb_dat_i[5:0] : 6'h00;

  // Sticky bits; a new event in the clearing cycle survives
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      evt_q <= 6'h00;
    end else begin
      evt_q <= evt_set | (evt_q & ~evt_clr);
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      mask_q <= 6'h00;
    end else if (bus_wr && wb_adr_i == ADR_MASK) begin
      mask_q <= wb_dat_i[5:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      irq_o_q <= 1'b0;
    end else begin
      irq_o_q <= |(evt_q & mask_q);
    end
  end

  // ----------------------------------------------------------------
  // Outputs, each from a flip-flop
  // ----------------------------------------------------------------
  assign wb_ack_o   = ack_q;
  assign wb_dat_o   = dat_q;
  assign irq_req    = irq_req_q;
  assign irq_vector = irq_vector_q;
  assign irq_source = irq_src_q;
  assign irq_o      = irq_o_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  property p_global_blocks;
    !global_irq_enable |=> !irq_req_q;
  endproperty
  a_global_blocks: assert property (p_global_blocks)
    else $error("request stands while global enable is low");

  property p_reserved_zero;
    interrupt_enable_reg_q[BIT_RSVD] == 1'b0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved enable bit holds a one");

  property p_req_enabled;
    $rose(irq_req_q) |-> ($past(interrupt_enable_reg_q[5:0]) & irq_src_q) != 6'h00;
  endproperty
  a_req_enabled: assert property (p_req_enabled)
    else $error("request from a disabled source");

  property p_src_onehot;
    irq_req_q |-> $onehot(irq_src_q);
  endproperty
  a_src_onehot: assert property (p_src_onehot)
    else $error("offered source is not one-hot");

  property p_serial_vec;
    irq_req_q && irq_src_q[SRC_SER] |-> irq_vector_q == 16'h0023;
  endproperty
  a_serial_vec: assert property (p_serial_vec)
    else $error("serial vector wrong");

  property p_t0_vec;
    irq_req_q && irq_src_q[SRC_T0] |-> irq_vector_q == 16'h000B;
  endproperty
  a_t0_vec: assert property (p_t0_vec)
    else $error("timer 0 vector wrong");

  property p_t2_vec;
    irq_req_q && irq_src_q[SRC_T2] |-> irq_vector_q == 16'h002B;
  endproperty
  a_t2_vec: assert property (p_t2_vec)
    else $error("timer 2 vector wrong");

  property p_t2_or;
    state2_phase2 |=> t2_latch_q == $past(timer2_overflow_flag | timer2_external_flag);
  endproperty
  a_t2_or: assert property (p_t2_or)
    else $error("timer 2 latch is not the OR of its flags");

  property p_t0_next_cycle;
    $rose(irq_req_q) && irq_src_q[SRC_T0] |-> $past(t01_latch_q[0]) ##0 $past(state5_phase2);
  endproperty
  a_t0_next_cycle: assert property (p_t0_next_cycle)
    else $error("timer 0 polled without an earlier latch");

  property p_t2_same_cycle;
    state2_phase2 |=> (!state5_phase2) [*5] ##1 state5_phase2;
  endproperty
  a_t2_same_cycle: assert property (p_t2_same_cycle)
    else $error("timer 2 latch point not six slots before the poll");

  property p_spi_gated;
    state5_phase2 && !irq_req_q && global_irq_enable && !uart_receive_flag &&
      !uart_transmit_flag && !spi_irq_enable |=> !(irq_req_q && irq_src_q[SRC_SER]);
  endproperty
  a_spi_gated: assert property (p_spi_gated)
    else $error("SPI flag requested with its enable low");

  property p_ack_keeps_req_off;
    irq_req_q && irq_ack && global_irq_enable |=> !irq_req_q [*2];
  endproperty
  a_ack_keeps_req_off: assert property (p_ack_keeps_req_off)
    else $error("request not withdrawn after acknowledge");

endmodule : iev_core

// [testbench/iev_cpu_model.sv]
/*
  CPU core model: takes each offered vector, promptly or slowly.
  Assumes the request protocol of the core on mclk.
*/
`timescale 1ns/1ps
module iev_cpu_model (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // Offer from the core
  input  wire logic        irq_req,
  input  wire logic [15:0] irq_vector,
  input  wire logic [5:0]  irq_source,
  input  wire logic        slow,
  // Answer and log
  output logic             irq_ack,
  output logic [21:0]      taken_q,
  output int               taken_n
);
  int wait_q;                      // Cycles the offer has stood

  // ------------------------------------------------------------
  // Ack after 0 or 6 cycles; flags are left for software
  // ------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      irq_ack <= 1'b0;
      wait_q  <= 0;
      taken_n <= 0;
      taken_q <= '0;
    end else if (irq_ack) begin    // One-cycle pulse only
      irq_ack <= 1'b0;
      wait_q  <= 0;
    end else if (irq_req && wait_q >= (slow ? 6 : 0)) begin
      irq_ack <= 1'b1;
      taken_q <= {irq_source, irq_vector};
      taken_n <= taken_n + 1;
    end else begin                 // Count while offered
      wait_q <= irq_req ? wait_q + 1 : 0;
    end
  end
endmodule : iev_cpu_model

// [testbench/test_iev_core.sv]
/*
  Self-checking bench of the interrupt enable and vector logic.
  Assumes iev_pkg and the CPU core model beside it.
*/
`timescale 1ns/1ps
module test_iev_core;
  import iev_pkg::*;
  logic mclk, rst_n, cyc, stb, we, ack, p0_n, p1_n, t0, t1, t2o, t2e;
  logic rx, tx, sd, se, iack, req, irq, slow, got;
  logic [7:0]  adr, r;
  logic [31:0] wdat, rdat, q;
  logic [15:0] vec;
  logic [5:0]  src;
  logic [21:0] tk;
  int mismatches, check_count, tk_n, cyc_n;
  int ready[$];                    // Model: pending sources, in order

  iev_core iev_core_inst (.mclk(mclk), .rst_n(rst_n), .wb_adr_i(adr),
    .wb_dat_i(wdat), .wb_sel_i(4'hF), .wb_we_i(we), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_dat_o(q), .wb_ack_o(ack), .ext_irq_pin_0_n(p0_n),
    .ext_irq_pin_1_n(p1_n), .timer0_overflow_flag(t0),
    .timer1_overflow_flag(t1), .timer2_overflow_flag(t2o),
    .timer2_external_flag(t2e), .uart_receive_flag(rx),
    .uart_transmit_flag(tx), .spi_done_flag(sd), .spi_irq_enable(se),
    .irq_ack(iack), .irq_req(req), .irq_vector(vec), .irq_source(src),
    .irq_o(irq));
  iev_cpu_model iev_cpu_model_inst (.mclk(mclk), .rst_n(rst_n),
    .irq_req(req), .irq_vector(vec), .irq_source(src), .slow(slow),
    .irq_ack(iack), .taken_q(tk), .taken_n(tk_n));

  // Clock, 5 ns period
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_of_test

  // Classic single cycle; held until ack is seen at an edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge mclk);
    while (ack !== 1'b1) @(posedge mclk);
    rdat = q;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
  endtask : idle

  // Wait for the CPU model to take a vector, bounded
  task automatic take;
    int n0;
    n0 = tk_n;
    for (int k = 0; k < 40 && tk_n == n0; k++) @(posedge mclk);
    got = (tk_n != n0);
  endtask : take

  task automatic src_on(input int i, input logic v);
    case (i)
      0: p0_n <= !v;
      1: t0 <= v;
      2: p1_n <= !v;
      3: t1 <= v;
      4: rx <= v;
      default: t2o <= v;
    endcase
  endtask : src_on

  // Hang guard
  always @(posedge mclk) begin
    cyc_n++;
    if (cyc_n == 10000) begin
      mismatches++;
      end_of_test();
    end
  end

  initial begin
    {cyc, stb, we, t0, t1, t2o, t2e, rx, tx, sd, se, slow} = '0;
    {p0_n, p1_n, rst_n} = 3'b110;
    {adr, wdat, r} = {8'h00, 32'h0000_0000, 8'h49};
    idle(8);
    rst_n <= 1'b1;
    wb(0, ADR_IE, 0);
    check(rdat, 32'h0);
    wb(1, ADR_IE, 32'hBF);
    wb(0, ADR_IE, 0);
    check(rdat, 32'hBF);
    wb(0, 8'h40, 0);
    check(rdat, 32'h0);
    wb(1, ADR_IE, 0);
    for (int i = 0; i < 6; i++) begin
      src_on(i, 1'b1);
      idle(26);
      wb(1, ADR_IE, (i % 2) ? 32'h3F : 32'h80 | (32'h3F & ~(32'h1 << i)));
      take();
      check(32'(got), 32'h0);
      slow <= ~slow;
      wb(1, ADR_IE, 32'h80 | (32'h1 << i));
      take();
      check(32'(got), 32'h1);
      check(32'(tk), {10'h0, 6'(1 << i), 16'h0003 + 16'(8 * i)});
      wb(1, ADR_IE, 0);
      src_on(i, 1'b0);
      idle(26);
    end
    check(32'(irq), 32'h0);
    wb(1, ADR_MASK, 32'h21);
    wb(0, ADR_EVT, 0);
    check(rdat, 32'h3F);
    check(32'(irq), 32'h1);
    wb(1, ADR_EVT, 32'h20);
    wb(1, ADR_EVT, 32'h01);
    idle(2);
    check(32'(irq), 32'h0);
    for (int n = 0; n < 12; n++) begin
      r = lfsr(r);
      {se, sd, tx, rx, t2e, t2o, t1, t0} <= r;
      ready.delete();
      if (r[0]) ready.push_back(1);
      if (r[1]) ready.push_back(3);
      if (r[4] | r[5] | (r[6] & r[7])) ready.push_back(4);
      if (r[2] | r[3]) ready.push_back(5);
      idle(26);
      wb(0, ADR_FLAGS, 0);
      check(rdat, {24'h0, r[7:2], 2'b00});
      wb(1, ADR_IE, 32'hBF);
      take();
      check(32'(got), 32'(ready.size() > 0));
      if (got) check(32'(tk), {10'h0, 6'(1 << ready[0]), 16'h0003 + 16'(8 * ready[0])});
      wb(1, ADR_IE, 0);
      {se, sd, tx, rx, t2e, t2o, t1, t0} <= 8'h00;
      idle(26);
    end
    end_of_test();
  end
endmodule : test_iev_core
